/* design/rotor_phasing_pkg.sv */
// Package with codes, field positions and carrier types for the rotor phasing decoder.
package rotor_phasing_pkg;

  // Sensor code bit positions: a is the most significant bit.
  localparam int unsigned SENSOR_A_POS = 2;
  localparam int unsigned SENSOR_B_POS = 1;
  localparam int unsigned SENSOR_C_POS = 0;

  // Codes that are invalid in each convention.
  localparam logic [2:0] BAD_60_LO  = 3'h2;
  localparam logic [2:0] BAD_60_HI  = 3'h5;
  localparam logic [2:0] BAD_120_LO = 3'h0;
  localparam logic [2:0] BAD_120_HI = 3'h7;

  // Reset values of the registered outputs.
  localparam logic [2:0] DRIVE_RESET = 3'h0;
  localparam logic       FAULT_N_RESET = 1'b0;

  // Phase indexes for drive vectors.
  localparam logic [1:0] PHASE_A = 2'h0;
  localparam logic [1:0] PHASE_B = 2'h1;
  localparam logic [1:0] PHASE_C = 2'h2;
  localparam logic [1:0] PHASE_NONE = 2'h3;

  // Protection inputs grouped together.
  typedef struct packed {
    logic output_enable;
    logic current_trip;
    logic undervoltage;
    logic thermal_trip;
  } protect_s;

  // Gate drive outputs, one bit per phase, bit 0 is phase a.
  typedef struct packed {
    logic [2:0] top;
    logic [2:0] bottom;
  } drive_s;

endpackage

/* design/pin_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,  // System clock.
  input  wire logic             rst_n,    // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] pin_in,   // Raw asynchronous input.
  output logic      [WIDTH-1:0] level_out // Settled level.
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_state_s;

  sync_state_s st_reg;
  sync_state_s st_next;

  // Stage one feeds only stage two; the level moves per bit where two and three agree.
  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pin_in;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;

endmodule // pin_sync3

/* design/rotor_sensor_phasing_decoder.sv */
// Six-step commutation decoder for three rotor sensors with selectable phasing.
// How it works
// - 60 degree order reversed gives 300 degree order.
// - 120 degree order reversed gives 240 degree order.
// - 60 setting runs 60 or 300 sensors.
// - 120 setting runs 120 or 240 sensors.
// - Valid code enables one top, one bottom, different phases.
// - Select link tied chooses 120, open chooses 60.
// - Output enable low forces all top drives off.
// - Fault low on invalid, disable, trip, undervoltage, thermal.
// - Code 100 swaps its pair with direction.
`timescale 1ns/1ns
module rotor_sensor_phasing_decoder (
  input  wire logic                        clk_sys,             // System clock, 100 MHz.
  input  wire logic                        rst_n,               // Asynchronous reset, active low.
  input  wire logic                        rotor_sensor_a,      // Rotor sensor a pin.
  input  wire logic                        rotor_sensor_b,      // Rotor sensor b pin.
  input  wire logic                        rotor_sensor_c,      // Rotor sensor c pin.
  input  wire logic                        phasing_select_link, // High selects 120/240 phasing.
  input  wire logic                        forward,             // High for forward direction.
  input  wire rotor_phasing_pkg::protect_s protect,             // Enable and protection pins.
  output rotor_phasing_pkg::drive_s        drive,               // Registered gate drives.
  output logic                             fault_n              // Fault indication, active low.
);

  // All pins come from outside the clock domain.
  logic [6:0] pins_raw;
  logic [6:0] pins_sync;
  assign pins_raw = {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c, phasing_select_link,
                     forward, protect.output_enable, protect.current_trip | protect.undervoltage
                     | protect.thermal_trip};

  pin_sync3 #(
    .WIDTH(7)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (pins_raw),
    .level_out(pins_sync)
  );

  logic [2:0] code;
  logic       sel_120;
  logic       dir_fwd;
  logic       enable;
  logic       trip;
  assign code    = pins_sync[6:4];
  assign sel_120 = pins_sync[3];
  assign dir_fwd = pins_sync[2];
  assign enable  = pins_sync[1];
  assign trip    = pins_sync[0];

  typedef struct packed {
    rotor_phasing_pkg::drive_s drv;
    logic                      fault_n;
  } dec_state_s;

  dec_state_s st_reg;
  dec_state_s st_next;

  // Step index 0..5 along the forward code order of the chosen convention, 6 if invalid.
  // Sensors of the reversed convention walk the same codes backwards, so the same table turns
  // the motor the other way without any extra logic.
  function automatic logic [2:0] step_of(input logic [2:0] c, input logic s120);
    logic [2:0] s;
    s = 3'h6;
    if (!s120) begin
      case (c)
        3'h4: s = 3'h0;
        3'h6: s = 3'h1;
        3'h7: s = 3'h2;
        3'h3: s = 3'h3;
        3'h1: s = 3'h4;
        3'h0: s = 3'h5;
        default: s = 3'h6;
      endcase
    end else begin
      case (c)
        3'h5: s = 3'h0;
        3'h4: s = 3'h1;
        3'h6: s = 3'h2;
        3'h2: s = 3'h3;
        3'h3: s = 3'h4;
        3'h1: s = 3'h5;
        default: s = 3'h6;
      endcase
    end
    return s;
  endfunction

  logic [2:0] step;
  logic [1:0] top_ph;
  logic [1:0] bot_ph;
  logic       valid;

  // Each step pairs a top phase and a different bottom phase; reverse swaps them.
  always_comb begin
    step   = step_of(code, sel_120);
    valid  = (step != 3'h6);
    top_ph = rotor_phasing_pkg::PHASE_NONE;
    bot_ph = rotor_phasing_pkg::PHASE_NONE;
    case (step)
      3'h0: begin
        top_ph = rotor_phasing_pkg::PHASE_A;
        bot_ph = rotor_phasing_pkg::PHASE_B;
      end
      3'h1: begin
        top_ph = rotor_phasing_pkg::PHASE_A;
        bot_ph = rotor_phasing_pkg::PHASE_C;
      end
      3'h2: begin
        top_ph = rotor_phasing_pkg::PHASE_B;
        bot_ph = rotor_phasing_pkg::PHASE_C;
      end
      3'h3: begin
        top_ph = rotor_phasing_pkg::PHASE_B;
        bot_ph = rotor_phasing_pkg::PHASE_A;
      end
      3'h4: begin
        top_ph = rotor_phasing_pkg::PHASE_C;
        bot_ph = rotor_phasing_pkg::PHASE_A;
      end
      3'h5: begin
        top_ph = rotor_phasing_pkg::PHASE_C;
        bot_ph = rotor_phasing_pkg::PHASE_B;
      end
      default: begin
        top_ph = rotor_phasing_pkg::PHASE_NONE;
        bot_ph = rotor_phasing_pkg::PHASE_NONE;
      end
    endcase
    if (!dir_fwd) begin
      {top_ph, bot_ph} = {bot_ph, top_ph};
    end
  end

  // Output stage: enable gates the top drives only; bottoms keep steering for braking.
  always_comb begin
    st_next            = st_reg;
    st_next.drv.top    = 3'h0;
    st_next.drv.bottom = 3'h0;
    if (valid) begin
      if (enable) begin
        st_next.drv.top[top_ph] = 1'b1;
      end
      st_next.drv.bottom[bot_ph] = 1'b1;
    end
    st_next.fault_n = valid && enable && !trip;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.drv.top    <= rotor_phasing_pkg::DRIVE_RESET;
      st_reg.drv.bottom <= rotor_phasing_pkg::DRIVE_RESET;
      st_reg.fault_n    <= rotor_phasing_pkg::FAULT_N_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign drive   = st_reg.drv;
  assign fault_n = st_reg.fault_n;

  property p_one_top_one_bottom;
    @(posedge clk_sys) disable iff (!rst_n)
      (valid && enable) |=> ($onehot(drive.top) && $onehot(drive.bottom)
                             && ((drive.top & drive.bottom) == 3'h0));
  endproperty
  a_one_top_one_bottom: assert property (p_one_top_one_bottom)
    else $error("Valid code did not give one top and one bottom on different phases.");

  property p_enable_low_tops_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !enable |=> (drive.top == 3'h0) && !fault_n;
  endproperty
  a_enable_low_tops_off: assert property (p_enable_low_tops_off)
    else $error("Top drive active or fault clear while disabled.");

  property p_invalid_all_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !valid |=> (drive.top == 3'h0) && (drive.bottom == 3'h0) && !fault_n;
  endproperty
  a_invalid_all_off: assert property (p_invalid_all_off)
    else $error("Invalid sensor code left a drive on or fault clear.");

  property p_trip_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      trip |=> !fault_n;
  endproperty
  a_trip_fault: assert property (p_trip_fault)
    else $error("Protection trip did not assert the fault.");

  property p_fault_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (valid && enable && !trip) |=> fault_n;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("Fault asserted with no cause.");

  property p_code100_fwd;
    @(posedge clk_sys) disable iff (!rst_n)
      (code == 3'h4 && dir_fwd && enable && !sel_120) |=> (drive.top == 3'h1)
                                                          && (drive.bottom == 3'h2);
  endproperty
  a_code100_fwd: assert property (p_code100_fwd)
    else $error("Code 100 forward gave the wrong pair.");

  property p_code100_rev;
    @(posedge clk_sys) disable iff (!rst_n)
      (code == 3'h4 && !dir_fwd && enable && !sel_120) |=> (drive.top == 3'h2)
                                                           && (drive.bottom == 3'h1);
  endproperty
  a_code100_rev: assert property (p_code100_rev)
    else $error("Code 100 reverse did not swap the pair.");

  property p_sel60_bad;
    @(posedge clk_sys) disable iff (!rst_n)
      (!sel_120 && (code == rotor_phasing_pkg::BAD_60_LO || code == rotor_phasing_pkg::BAD_60_HI))
        |=> !fault_n;
  endproperty
  a_sel60_bad: assert property (p_sel60_bad)
    else $error("Code invalid for 60 degree phasing accepted.");

  property p_sel120_bad;
    @(posedge clk_sys) disable iff (!rst_n)
      (sel_120 && (code == rotor_phasing_pkg::BAD_120_LO
                   || code == rotor_phasing_pkg::BAD_120_HI)) |=> !fault_n;
  endproperty
  a_sel120_bad: assert property (p_sel120_bad)
    else $error("Code invalid for 120 degree phasing accepted.");

  property p_step_advance;
    @(posedge clk_sys) disable iff (!rst_n)
      (valid && $past(valid) && step != $past(step)) |->
        (step == (($past(step) == 3'h5) ? 3'h0 : $past(step) + 3'h1)
         || $past(step) == ((step == 3'h5) ? 3'h0 : step + 3'h1) || $changed(sel_120));
  endproperty
  a_step_advance: assert property (p_step_advance)
    else $error("Sensor code skipped a step.");

endmodule // rotor_sensor_phasing_decoder

/* verification/rotor_sensor_model.sv */
// Behavioural rotor sensor set that presents the code for a given rotor position.
`timescale 1ns/1ns
module rotor_sensor_model (
  input  wire logic [2:0] pos,      // Rotor position, one of six 60 degree sectors.
  input  wire logic [1:0] conv,     // Sensor convention: 0=60, 1=120, 2=240, 3=300.
  input  wire logic       bad,      // High presents a code invalid for the convention.
  input  wire logic       bad_hi,   // Picks which of the two invalid codes.
  output logic            sensor_a, // Sensor a level.
  output logic            sensor_b, // Sensor b level.
  output logic            sensor_c  // Sensor c level.
);
  logic [2:0] t60 [6];
  logic [2:0] t120 [6];
  logic [2:0] code;
  logic       m120;

  // Sector codes of the two base conventions; the others walk them backwards.
  assign t60  = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  assign t120 = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  assign m120 = (conv == 2'h1) || (conv == 2'h2);

  // One code per sector, so the code changes every 60 electrical degrees.
  always_comb begin
    case (conv)
      2'h0: code = t60[pos];
      2'h1: code = t120[pos];
      2'h2: code = t120[3'h5 - pos];
      default: code = t60[3'h5 - pos];
    endcase
    if (bad) begin
      code = m120 ? (bad_hi ? 3'h7 : 3'h0) : (bad_hi ? 3'h5 : 3'h2);
    end
  end

  assign {sensor_a, sensor_b, sensor_c} = code;
endmodule // rotor_sensor_model

/* verification/tb_top.sv */
// Self-checking bench for the rotor phasing decoder.
`timescale 1ns/1ns
module tb_top;
  logic                        clk_sys = 1'b0;
  logic                        rst_n   = 1'b0;
  logic                        sa, sb, sc;
  logic                        sel     = 1'b0;
  logic                        fwd     = 1'b1;
  logic [2:0]                  pos     = 3'h0;
  logic [1:0]                  conv    = 2'h0;
  logic                        bad     = 1'b0;
  logic                        bad_hi  = 1'b0;
  rotor_phasing_pkg::protect_s prot    = 4'h8;
  rotor_phasing_pkg::drive_s   drive;
  logic                        fault_n;
  int                          miscompares = 0;
  int                          checked     = 0;
  int                          bot_ph [6]  = '{1, 2, 2, 0, 0, 1};

  // Free-running 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  rotor_sensor_model u_sensors (.pos(pos), .conv(conv), .bad(bad), .bad_hi(bad_hi),
    .sensor_a(sa), .sensor_b(sb), .sensor_c(sc));

  rotor_sensor_phasing_decoder u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .rotor_sensor_a(sa),
    .rotor_sensor_b(sb), .rotor_sensor_c(sc), .phasing_select_link(sel), .forward(fwd),
    .protect(prot), .drive(drive), .fault_n(fault_n));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_drive(input rotor_phasing_pkg::drive_s got,
                           input rotor_phasing_pkg::drive_s exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: drive %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: fault_n %b expected %b", $time, got, exp);
    end
  endtask

  // Three sync stages, the settled level and the output register put an input change on the
  // outputs at the fifth edge; look just after it, off the edge.
  task automatic settle();
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Every sector of every convention in both directions.
  task automatic t_rotation();
    int                        s;
    rotor_phasing_pkg::drive_s e;
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 2; d++) begin
        for (int p = 0; p < 6; p++) begin
          @(posedge clk_sys);
          conv <= 2'(c);
          sel <= (c == 1) || (c == 2);
          fwd <= d[0];
          pos <= 3'(p);
          settle();
          s = (c < 2) ? p : 5 - p;
          e.top = 3'h1 << (s / 2);
          e.bottom = 3'h1 << bot_ph[s];
          if (d == 0) e = {e.bottom, e.top};
          chk_drive(drive, e);
          chk_bit(fault_n, 1'b1);
        end
      end
    end
    $display("test rotation done");
  endtask

  // Both invalid codes of the 60 and 120 conventions drop all drives and flag a fault.
  task automatic t_invalid();
    for (int m = 0; m < 2; m++) begin
      for (int h = 0; h < 2; h++) begin
        @(posedge clk_sys);
        conv <= 2'(m);
        sel <= m[0];
        bad <= 1'b1;
        bad_hi <= h[0];
        settle();
        chk_drive(drive, 6'h00);
        chk_bit(fault_n, 1'b0);
      end
    end
    @(posedge clk_sys);
    bad <= 1'b0;
    $display("test invalid done");
  endtask

  // Disable clears only the top drives; each trip only flags a fault.
  task automatic t_protect();
    @(posedge clk_sys);
    conv <= 2'h0;
    sel <= 1'b0;
    fwd <= 1'b1;
    pos <= 3'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      prot <= (i == 0) ? 4'h0 : (4'h8 | (4'h8 >> i));
      settle();
      chk_drive(drive, (i == 0) ? 6'h02 : 6'h0a);
      chk_bit(fault_n, 1'b0);
    end
    @(posedge clk_sys);
    prot <= 4'h8;
    settle();
    chk_bit(fault_n, 1'b1);
    $display("test protect done");
  endtask

  // Reset held, released, then taken again after the last test.
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_drive(drive, 6'h00);
    chk_bit(fault_n, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_rotation();
    t_invalid();
    t_protect();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk_drive(drive, 6'h00);
    chk_bit(fault_n, 1'b0);
    wrap_up();
  end

  // A hang would stop well past the tests' few hundred cycles; allow plenty.
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end
endmodule // tb_top
